/* File: atfc_top.sv */
// Overview of operation
// - A set justify bit stores the result right-justified, a clear bit left-justified.
// - Acquisition codes 111 down to 001 wait 20, 16, 12, 8, 6, 4 or 2 conversion clock periods.
// - Clock codes 000, 001, 010, 100, 101, 110 divide the system clock by 2, 8, 32, 4, 16, 64.
// - Clock codes 011 and 111 take the internal RC oscillator as conversion clock.
// - With the RC clock, its first period starts one instruction cycle after the request.
`timescale 1ns/1ps
module atfc_top
   import atfc_pkg::*;
#(
   parameter int RC_PERIOD = RC_PERIOD_NS
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output      logic [31:0]       hrdata,
   output      logic              hreadyout,
   output      logic              hresp,
   // Converter core
   output      logic              acquiring,
   output      logic              converting,
   output      logic              conversion_clock_period,
   input  wire logic              conv_done,
   input  wire logic [RAW_W-1:0]  conv_data
);

   localparam int RC_CYCLES = (RC_PERIOD + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Bus phase capture
   logic                ap_valid;
   logic                ap_write;
   logic [3:0]          ap_addr;
   logic                ap_take;

   // Registers
   atfc_ctrl_t          converter_control_two;
   atfc_ctrl_t          next_ctrl;
   logic                run_justify;
   logic                result_ready;
   logic                overrun;
   logic [RESULT_W-1:0] result;
   logic [COUNT_W-1:0]  conv_count;

   // Internal events
   logic                wr_ctrl;
   logic                wr_cmd;
   logic                go_req;
   logic                start;
   logic                busy;
   logic                finish;
   logic                tad_tick;
   atfc_state_t         state;

   // Zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign ap_take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr  <= 4'h0;
      end else if (hready) begin
         ap_valid <= ap_take;
         ap_write <= hwrite;
         ap_addr  <= {haddr[3:2], 2'b00};
      end
   end

   assign wr_ctrl = ap_valid && ap_write && (ap_addr == OFS_CTRL_TWO);
   assign wr_cmd  = ap_valid && ap_write && (ap_addr == OFS_COMMAND);
   assign go_req  = wr_cmd && hwdata[POS_GO_BUSY];
   // A request while busy is dropped and flagged
   assign start   = go_req && !busy;

   // Unimplemented bit 6 stays zero
   always_comb begin
      next_ctrl = converter_control_two;
      if (wr_ctrl) begin
         next_ctrl = atfc_ctrl_t'(hwdata[7:0] & CTRL_WR_MASK);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         converter_control_two <= atfc_ctrl_t'(CTRL_RESET);
      end else begin
         converter_control_two <= next_ctrl;
      end
   end

   // Justify choice is held for the running conversion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_justify <= 1'b0;
      end else if (start) begin
         run_justify <= next_ctrl.justify;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result <= '0;
      end else if (finish) begin
         if (run_justify) begin
            result <= {{(RESULT_W-RAW_W){1'b0}}, conv_data};
         end else begin
            result <= {conv_data, {(RESULT_W-RAW_W){1'b0}}};
         end
      end
   end

   // Sticky flags, write one to clear; a new event wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_ready <= 1'b0;
      end else if (finish) begin
         result_ready <= 1'b1;
      end else if (wr_cmd && hwdata[POS_READY]) begin
         result_ready <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overrun <= 1'b0;
      end else if (go_req && busy) begin
         overrun <= 1'b1;
      end else if (wr_cmd && hwdata[POS_OVERRUN]) begin
         overrun <= 1'b0;
      end
   end

   // Completed conversions, wraps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_count <= '0;
      end else if (finish) begin
         conv_count <= conv_count + COUNT_W'(1);
      end
   end

   // Read data is sampled in the address phase from the values
   // the pending write will leave for the control byte, busy and flag clears, not for an overrun it sets or the acquisition and conversion bits.
   function automatic logic [31:0] read_word(input logic [3:0] addr);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (addr)
         OFS_CTRL_TWO: w[7:0] = next_ctrl;
         OFS_COMMAND: begin
            w[POS_GO_BUSY] = busy || start;
            w[POS_READY]   = result_ready && !(wr_cmd && hwdata[POS_READY]);
            w[POS_OVERRUN] = overrun && !(wr_cmd && hwdata[POS_OVERRUN]);
            w[POS_ACQ_ON]  = (state == ATFC_ACQ);
            w[POS_CONV_ON] = (state == ATFC_CONV);
         end
         OFS_RESULT: w[RESULT_W-1:0] = result;
         OFS_COUNT:  w[COUNT_W-1:0]  = conv_count;
         default:    w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_take && !hwrite) begin
         hrdata <= read_word({haddr[3:2], 2'b00});
      end
   end

   atfc_tad_gen #(
      .RC_CYCLES (RC_CYCLES)
   ) u_tad_gen (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .start    (start),
      .run      (busy),
      .sel      (next_ctrl.clk_sel),
      .tad_tick (tad_tick)
   );

   atfc_seq u_seq (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .start     (start),
      .acq_sel   (next_ctrl.acq_sel),
      .tad_tick  (tad_tick),
      .conv_done (conv_done),
      .state     (state),
      .busy      (busy),
      .finish    (finish)
   );

   // Phase outputs come from flops to keep the core glitch free
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acquiring               <= 1'b0;
         converting              <= 1'b0;
         conversion_clock_period <= 1'b0;
      end else begin
         acquiring               <= (state == ATFC_ACQ) && !(tad_tick && finish);
         converting              <= (state == ATFC_CONV) && !conv_done;
         conversion_clock_period <= tad_tick;
      end
   end

endmodule

/* File: atfc_pkg.sv */
package atfc_pkg;

   // Register byte offsets
   localparam logic [3:0] OFS_CTRL_TWO = 4'h0;
   localparam logic [3:0] OFS_COMMAND  = 4'h4;
   localparam logic [3:0] OFS_RESULT   = 4'h8;
   localparam logic [3:0] OFS_COUNT    = 4'hc;

   // converter_control_two field positions and reset value
   localparam int         POS_JUSTIFY  = 7;
   localparam int         POS_ACQ_LSB  = 3;
   localparam int         POS_CLK_LSB  = 0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK = 8'hbf;

   // Command and status bit positions
   localparam int POS_GO_BUSY = 0;
   localparam int POS_READY   = 1;
   localparam int POS_OVERRUN = 2;
   localparam int POS_ACQ_ON  = 4;
   localparam int POS_CONV_ON = 5;

   // Converter data
   localparam int RAW_W    = 10;
   localparam int RESULT_W = 16;
   localparam int COUNT_W  = 16;

   // Timing: system clock, instruction cycle, divider widths
   localparam int CLK_PERIOD_NS   = 4;
   localparam int INSTR_CYCLE_NS  = 16;
   localparam int TCY_CYCLES      = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_PERIOD_NS    = 1000;
   localparam int DIV_W           = 12;
   localparam int HOLD_W          = 4;
   localparam int TAD_CNT_W       = 5;

   // Control fields, same layout as the register
   typedef struct packed {
      logic       justify;
      logic       reserved;
      logic [2:0] acq_sel;
      logic [2:0] clk_sel;
   } atfc_ctrl_t;

   // Sequencer state, one-hot
   typedef enum logic [2:0] {
      ATFC_IDLE = 3'b001,
      ATFC_ACQ  = 3'b010,
      ATFC_CONV = 3'b100
   } atfc_state_t;

   // Acquisition length in conversion clock periods
   function automatic logic [TAD_CNT_W-1:0] acq_periods(input logic [2:0] code);
      logic [TAD_CNT_W-1:0] n;
      n = 5'h00;
      unique case (code)
         3'b111: n = 5'h14;
         3'b110: n = 5'h10;
         3'b101: n = 5'h0c;
         3'b100: n = 5'h08;
         3'b011: n = 5'h06;
         3'b010: n = 5'h04;
         3'b001: n = 5'h02;
         3'b000: n = 5'h00;
      endcase
      return n;
   endfunction

   // Internal RC source selected
   function automatic logic is_rc_source(input logic [2:0] code);
      return (code == 3'b011) || (code == 3'b111);
   endfunction

   // System clock divide ratio; RC codes return zero
   function automatic logic [DIV_W-1:0] osc_divide(input logic [2:0] code);
      logic [DIV_W-1:0] d;
      d = 12'h000;
      unique case (code)
         3'b000: d = 12'h002;
         3'b001: d = 12'h008;
         3'b010: d = 12'h020;
         3'b100: d = 12'h004;
         3'b101: d = 12'h010;
         3'b110: d = 12'h040;
         3'b011,
         3'b111: d = 12'h000;
      endcase
      return d;
   endfunction

endpackage

/* File: atfc_tad_gen.sv */
`timescale 1ns/1ps
module atfc_tad_gen
   import atfc_pkg::*;
#(
   parameter int RC_CYCLES = 250
) (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Control
   input  wire logic       start,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   // Conversion clock enable
   output      logic       tad_tick
);

   logic [2:0]        sel_q;
   logic              run_q;
   logic [HOLD_W-1:0] hold;
   logic [DIV_W-1:0]  cnt;
   logic [DIV_W-1:0]  period;

   assign period   = is_rc_source(sel_q) ? DIV_W'(RC_CYCLES) : osc_divide(sel_q);
   assign tad_tick = run_q && (hold == '0) && (cnt == period - DIV_W'(1));

   // Source is frozen for the whole conversion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q <= 3'h0;
         run_q <= 1'b0;
      end else if (start) begin
         sel_q <= sel;
         run_q <= 1'b1;
      end else if (!run) begin
         run_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold <= '0;
      end else if (start) begin
         hold <= is_rc_source(sel) ? HOLD_W'(TCY_CYCLES) : '0;
      end else if (hold != '0) begin
         hold <= hold - HOLD_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
      end else if (start || !run_q || hold != '0 || tad_tick) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + DIV_W'(1);
      end
   end

endmodule

/* File: atfc_seq.sv */
`timescale 1ns/1ps
module atfc_seq
   import atfc_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Control
   input  wire logic        start,
   input  wire logic [2:0]  acq_sel,
   input  wire logic        tad_tick,
   input  wire logic        conv_done,
   // State
   output      atfc_state_t state,
   output      logic        busy,
   output      logic        finish
);

   logic [TAD_CNT_W-1:0] target;
   logic [TAD_CNT_W-1:0] ticks;
   atfc_state_t          next_state;

   assign busy   = (state != ATFC_IDLE);
   assign finish = (state == ATFC_CONV) && conv_done;

   always_comb begin
      next_state = state;
      unique case (state)
         ATFC_IDLE: begin
            if (start) begin
               next_state = (acq_periods(acq_sel) == '0) ? ATFC_CONV : ATFC_ACQ;
            end
         end
         ATFC_ACQ: begin
            if (tad_tick && ticks == target - TAD_CNT_W'(1)) begin
               next_state = ATFC_CONV;
            end
         end
         ATFC_CONV: begin
            if (conv_done) begin
               next_state = ATFC_IDLE;
            end
         end
         default: next_state = ATFC_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ATFC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Count periods of the acquisition window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         target <= '0;
         ticks  <= '0;
      end else if (state == ATFC_IDLE) begin
         target <= acq_periods(acq_sel);
         ticks  <= '0;
      end else if (state == ATFC_ACQ && tad_tick) begin
         ticks <= ticks + TAD_CNT_W'(1);
      end
   end

endmodule

/* File: atfc_chk.sv */
`timescale 1ns/1ps
module atfc_chk
   import atfc_pkg::*;
#(
   parameter int RC_PERIOD = RC_PERIOD_NS
) (
   // Clock and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   // Converter side
   input wire logic        acquiring,
   input wire logic        converting,
   input wire logic        conversion_clock_period
);
   localparam int RCC = (RC_PERIOD + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   localparam int NACQ [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   logic       wp;
   logic       first;
   logic       act;
   logic [1:0] wa;
   logic [7:0] ctrl;
   logic [7:0] lat;
   int         gap;
   int         np;
   wire go = wp && wa == 2'h1 && hwdata[0] && !act && !acquiring && !converting;
   wire rc = lat[1:0] == 2'h3;
   wire tick = conversion_clock_period;

   // Shadow of the control register, latched at go
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'b0;
         wa <= 2'h0;
         ctrl <= 8'h00;
         lat <= 8'h00;
      end else begin
         wp <= hsel && hready && htrans[1] && hwrite;
         wa <= haddr[3:2];
         if (wp && wa == 2'h0) ctrl <= hwdata[7:0];
         if (go) lat <= ctrl;
      end
   end

   // Phase outputs lag a taken go by two cycles; a go there is refused
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act <= 1'b0;
      end else if (go) begin
         act <= 1'b1;
      end else if (acquiring || converting) begin
         act <= 1'b0;
      end
   end

   // Spacing of conversion clock pulses since go
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap <= 0;
         np <= 0;
         first <= 1'b0;
      end else if (go) begin
         gap <= 1;
         np <= 0;
         first <= 1'b1;
      end else begin
         gap <= tick ? 1 : gap + 1;
         if (tick) np <= np + 1;
         if (tick) first <= 1'b0;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_pulse; tick |=> !tick; endproperty
   a_pulse: assert property (p_pulse) else $error("clock pulse too long");
   property p_div; tick && acquiring && !first && !rc |-> gap == DIV[lat[2:0]]; endproperty
   a_div: assert property (p_div) else $error("divided spacing wrong");
   property p_rc; tick && acquiring && !first && rc |-> gap == RCC; endproperty
   a_rc: assert property (p_rc) else $error("rc spacing wrong");
   property p_hold; tick && first && rc |-> gap >= TCY_CYCLES + RCC; endproperty
   a_hold: assert property (p_hold) else $error("rc start too early");
   property p_acq_n; $fell(acquiring) |-> np == NACQ[lat[2:0]]; endproperty
   a_acq_n: assert property (p_acq_n) else $error("acquisition length wrong");
   property p_acq_go; go && ctrl[5:3] != 3'h0 |-> ##[1:3] acquiring; endproperty
   a_acq_go: assert property (p_acq_go) else $error("no acquisition");
   property p_no_acq; go && ctrl[5:3] == 3'h0 |=> !acquiring [*4]; endproperty
   a_no_acq: assert property (p_no_acq) else $error("acquired on code zero");
   property p_conv; go && ctrl[5:3] == 3'h0 |-> ##[1:3] converting; endproperty
   a_conv: assert property (p_conv) else $error("no direct conversion");
endmodule

/* File: test_atfc_top.sv */
`timescale 1ns/1ps
module test_atfc_top;
   import atfc_pkg::*;
   localparam int RCP = 20;
   localparam int DV [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   localparam int NA [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic             hsel = 1'b0;
   logic [31:0]      haddr = 32'h0;
   logic [1:0]       htrans = 2'h0;
   logic             hwrite = 1'b0;
   logic [2:0]       hsize = 3'h2;
   logic [31:0]      hwdata = 32'h0;
   logic             conv_done = 1'b0;
   logic [RAW_W-1:0] conv_data = 10'h000;
   logic [31:0]      hrdata;
   logic [31:0]      rd;
   logic             hreadyout;
   logic             hresp;
   logic             acquiring;
   logic             converting;
   logic             ccp;
   int               n_errors = 0;
   int               checks_done = 0;

   always #2 hclk = ~hclk;

   atfc_top #(.RC_PERIOD(RCP)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .acquiring(acquiring), .converting(converting), .conversion_clock_period(ccp),
      .conv_done(conv_done), .conv_data(conv_data));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One single word transfer; entered just after a rising edge
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {28'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic regs();
      bus(4'h0, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      bus(4'h0, 1'b1, 32'hff);
      bus(4'h0, 1'b0, 32'h0);
      chk(rd, 32'hbf);
      // Result and count are read only
      bus(4'h8, 1'b1, 32'h3ff);
      bus(4'hc, 1'b1, 32'h7);
      bus(4'h8, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(4'hc, 1'b0, 32'h0);
      chk(rd, 32'h0);
   endtask

   // Acquisition code i, clock code i, justify from bit 0 of i
   task automatic run(input int i);
      int         np;
      int         last;
      int         gap;
      int         first;
      int         cyc;
      logic [9:0] d;
      np = 0;
      last = 0;
      gap = 0;
      first = 0;
      cyc = 0;
      d = 10'h2c3 ^ 10'(i);
      bus(4'h0, 1'b1, {24'h0, i[0], 1'b0, i[2:0], i[2:0]});
      bus(4'h4, 1'b1, 32'h1);
      while (converting !== 1'b1 && cyc < 3000) begin
         @(posedge hclk);
         cyc++;
         if (ccp === 1'b1) begin
            if (np == 0) first = cyc;
            gap = cyc - last;
            last = cyc;
            np++;
         end
      end
      chk(32'(np), 32'(NA[i]));
      if (i == 3 || i == 7) begin
         chk(32'(gap), 32'(RCP / CLK_PERIOD_NS));
         chk({31'h0, first >= TCY_CYCLES + RCP / CLK_PERIOD_NS}, 32'h1);
      end else if (i > 0) chk(32'(gap), 32'(DV[i]));
      conv_data <= d;
      conv_done <= 1'b1;
      @(posedge hclk);
      conv_done <= 1'b0;
      repeat (2) @(posedge hclk);
      bus(4'h8, 1'b0, 32'h0);
      chk(rd, i[0] ? {22'h0, d} : {16'h0, d, 6'h0});
      bus(4'h4, 1'b0, 32'h0);
      chk(rd, 32'h2);
      bus(4'hc, 1'b0, 32'h0);
      chk(rd, 32'(i + 1));
      bus(4'h4, 1'b1, 32'h2);
   endtask

   // Second go during a long acquisition is refused and flagged
   task automatic over();
      bus(4'h0, 1'b1, 32'h3e);
      bus(4'h4, 1'b1, 32'h1);
      bus(4'h4, 1'b1, 32'h1);
      bus(4'h4, 1'b0, 32'h0);
      chk(rd, 32'h15);
      bus(4'h4, 1'b1, 32'h4);
      bus(4'h4, 1'b0, 32'h0);
      chk(rd, 32'h11);
   endtask

   task automatic close_out();
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      regs();
      for (int i = 0; i < 8; i++) run(i);
      over();
      close_out();
   end

   // Whole run needs some 1700 cycles
   initial begin
      #200000;
      n_errors++;
      close_out();
   end
endmodule

bind atfc_top atfc_chk #(.RC_PERIOD(RC_PERIOD)) i_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .acquiring(acquiring),
   .converting(converting), .conversion_clock_period(conversion_clock_period));
